// ==== core/ccp_pkg.sv ====
package ccp_pkg;
  // register offsets on the 12-bit serial address
  localparam logic [11:0] SOFTWARE_RESET_ADDR = 12'h000;
  localparam logic [11:0] OUTPUT_INTERFACE_CONFIG_ADDR = 12'h007;
  localparam logic [11:0] BLOCK_POWER_DOWN_ADDR = 12'h008;
  localparam logic [11:0] OUTPUT_BUFFER_POWER_DOWN_ADDR = 12'h009;

  // value after reset of every register
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // software_reset fields
  localparam int RESET_BIT = 0;

  // output_interface_config fields
  localparam int LANE_MAP_MSB = 7;
  localparam int LANE_MAP_LSB = 5;
  localparam int MODE_OVERRIDE_BIT = 3;
  localparam int MODE_SELECT_MSB = 2;
  localparam int MODE_SELECT_LSB = 0;

  // block_power_down fields
  localparam int SAMPLE_CLOCK_BUFFER_OFF_BIT = 5;
  localparam int REFERENCE_AMP_OFF_BIT = 4;
  localparam int FIRST_CHANNEL_OFF_BIT = 2;
  localparam int SECOND_CHANNEL_OFF_BIT = 1;
  localparam int GLOBAL_POWERDOWN_BIT = 0;

  // output_buffer_power_down fields
  localparam int FRAME_CLOCK_OUTPUT_OFF_BIT = 5;
  localparam int BIT_CLOCK_OUTPUT_OFF_BIT = 4;
  localparam int FIRST_CHANNEL_LANE1_OFF_BIT = 3;
  localparam int FIRST_CHANNEL_LANE0_OFF_BIT = 2;
  localparam int SECOND_CHANNEL_LANE1_OFF_BIT = 1;
  localparam int SECOND_CHANNEL_LANE0_OFF_BIT = 0;

  // lane mapping codes
  localparam logic [2:0] LANE_MAP_NONE = 3'h0;
  localparam logic [2:0] LANE_MAP_TWO_WIRE_18_14 = 3'h1;
  localparam logic [2:0] LANE_MAP_TWO_WIRE_16 = 3'h2;
  localparam logic [2:0] LANE_MAP_ONE_WIRE = 3'h3;
  localparam logic [2:0] LANE_MAP_HALF_WIRE = 3'h4;

  // output mode codes
  localparam logic [2:0] MODE_TWO_WIRE = 3'h3;
  localparam logic [2:0] MODE_ONE_WIRE = 3'h4;
  localparam logic [2:0] MODE_HALF_WIRE = 3'h5;

  // serial frame: read flag, three spare bits, 12 address bits, 8 data bits
  localparam int FRAME_BITS = 24;
  localparam logic [4:0] LAST_BIT_INDEX = 5'h17;
  localparam logic [4:0] LAST_ADDR_BIT_INDEX = 5'h0f;
endpackage

// ==== core/ccp_serial_port.sv ====
`timescale 1ns/1ps
module ccp_serial_port
  import ccp_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial pins
  input wire logic senN,
  input wire logic sdataIn,
  output logic sdataOut,
  // register side
  output logic writeStrobe,
  output logic [11:0] writeAddr,
  output logic [7:0] writeData,
  output logic [11:0] readAddr,
  input wire logic [7:0] readData
);
  logic [22:0] shiftIn;
  logic [4:0] bitIndex;
  logic [7:0] shiftOut;
  logic readFlag16;

  // address seen once the 16th bit is on the pin
  assign readAddr = {shiftIn[10:0], sdataIn};
  assign readFlag16 = shiftIn[14];
  assign sdataOut = shiftOut[7];

  // shift in and count; an idle enable restarts the frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shiftIn <= 23'h000000;
      bitIndex <= 5'h00;
    end else if (senN) begin
      bitIndex <= 5'h00;
    end else begin
      shiftIn <= {shiftIn[21:0], sdataIn};
      if (bitIndex != LAST_BIT_INDEX) begin
        bitIndex <= bitIndex + 5'h01;
      end else begin
        bitIndex <= 5'h00;
      end
    end
  end

  // write strobe after the last data bit of a write frame
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      writeStrobe <= 1'b0;
      writeAddr <= 12'h000;
      writeData <= 8'h00;
    end else begin
      writeStrobe <= !senN && bitIndex == LAST_BIT_INDEX && !shiftIn[22];
      if (!senN && bitIndex == LAST_BIT_INDEX) begin
        writeAddr <= shiftIn[18:7];
        writeData <= {shiftIn[6:0], sdataIn};
      end
    end
  end

  // read data loaded after the address, then shifted out msb first
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shiftOut <= 8'h00;
    end else if (senN) begin
      shiftOut <= 8'h00;
    end else if (bitIndex == LAST_ADDR_BIT_INDEX && readFlag16) begin
      shiftOut <= readData;
    end else begin
      shiftOut <= {shiftOut[6:0], 1'b0};
    end
  end
endmodule

// ==== core/ccp_regs.sv ====
`timescale 1ns/1ps
module ccp_regs
  import ccp_pkg::*;
(
  // serial clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // serial programming pins
  input wire logic senN,
  input wire logic sdataIn,
  output logic sdataOut,
  // fuse defaults and fuse load command
  input wire logic [2:0] fuseLaneMapping,
  input wire logic [2:0] fuseOutputMode,
  input wire logic fuseLoadCmd,
  // global power-down mask
  input wire logic maskClockBuffer,
  input wire logic maskReferenceAmp,
  input wire logic maskBandgapDisable,
  // active interface setting
  output logic [2:0] laneBitMapping,
  output logic [2:0] outputMode,
  // analog power controls
  output logic sampleClockBufferOff,
  output logic referenceAmpOff,
  output logic firstChannelOff,
  output logic secondChannelOff,
  output logic bandgapOff,
  // output buffer power controls
  output logic frameClockOutputOff,
  output logic bitClockOutputOff,
  output logic firstChannelLane0Off,
  output logic firstChannelLane1Off,
  output logic secondChannelLane0Off,
  output logic secondChannelLane1Off
);
  logic writeStrobe;
  logic [11:0] writeAddr;
  logic [7:0] writeData;
  logic [11:0] readAddr;
  logic [7:0] readData;
  logic [7:1] resetSpare;
  logic [7:0] interfaceConfig;
  logic [7:0] blockPowerDown;
  logic [7:0] bufferPowerDown;
  logic softResetHit;
  logic fusesLoaded;
  logic [2:0] defaultMode;
  logic globalOn;

  ccp_serial_port serialPort (
    .clock(clock),
    .rst_n(rst_n),
    .senN(senN),
    .sdataIn(sdataIn),
    .sdataOut(sdataOut),
    .writeStrobe(writeStrobe),
    .writeAddr(writeAddr),
    .writeData(writeData),
    .readAddr(readAddr),
    .readData(readData)
  );

  assign softResetHit = writeStrobe && writeAddr == SOFTWARE_RESET_ADDR
    && writeData[RESET_BIT];

  // register writes; reserved bits kept as ordinary storage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resetSpare <= 7'h00;
      interfaceConfig <= REG_RESET_VALUE;
      blockPowerDown <= REG_RESET_VALUE;
      bufferPowerDown <= REG_RESET_VALUE;
    end else if (softResetHit) begin
      resetSpare <= 7'h00;
      interfaceConfig <= REG_RESET_VALUE;
      blockPowerDown <= REG_RESET_VALUE;
      bufferPowerDown <= REG_RESET_VALUE;
    end else if (writeStrobe) begin
      if (writeAddr == SOFTWARE_RESET_ADDR) begin
        resetSpare <= writeData[7:1];
      end else if (writeAddr == OUTPUT_INTERFACE_CONFIG_ADDR) begin
        interfaceConfig <= writeData;
      end else if (writeAddr == BLOCK_POWER_DOWN_ADDR) begin
        blockPowerDown <= writeData;
      end else if (writeAddr == OUTPUT_BUFFER_POWER_DOWN_ADDR) begin
        bufferPowerDown <= writeData;
      end
    end else if (fuseLoadCmd) begin
      // fuse load wipes the power-down registers, but keeps the interface setup
      blockPowerDown <= REG_RESET_VALUE;
      bufferPowerDown <= REG_RESET_VALUE;
    end
  end

  // read mux; the reset bit always reads back zero
  always_comb begin
    readData = 8'h00;
    if (readAddr == SOFTWARE_RESET_ADDR) begin
      readData = {resetSpare, 1'b0};
    end else if (readAddr == OUTPUT_INTERFACE_CONFIG_ADDR) begin
      readData = interfaceConfig;
    end else if (readAddr == BLOCK_POWER_DOWN_ADDR) begin
      readData = blockPowerDown;
    end else if (readAddr == OUTPUT_BUFFER_POWER_DOWN_ADDR) begin
      readData = bufferPowerDown;
    end
  end

  // fuse defaults are caught after reset release, never under reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fusesLoaded <= 1'b0;
      defaultMode <= 3'h0;
    end else if (softResetHit) begin
      fusesLoaded <= 1'b0;
    end else if (!fusesLoaded) begin
      fusesLoaded <= 1'b1;
      defaultMode <= fuseOutputMode;
    end
  end

  // active lane mapping: fuse default, replaced by a fuse load; a soft reset brings back the fuse default
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      laneBitMapping <= LANE_MAP_NONE;
    end else if (!fusesLoaded) begin
      laneBitMapping <= fuseLaneMapping;
    end else if (fuseLoadCmd) begin
      // unused codes fall back to the fuse mapping
      if (interfaceConfig[LANE_MAP_MSB:LANE_MAP_LSB] >= LANE_MAP_TWO_WIRE_18_14
          && interfaceConfig[LANE_MAP_MSB:LANE_MAP_LSB] <= LANE_MAP_HALF_WIRE) begin
        laneBitMapping <= interfaceConfig[LANE_MAP_MSB:LANE_MAP_LSB];
      end else begin
        laneBitMapping <= fuseLaneMapping;
      end
    end
  end

  // active output mode; unused select codes fall back to the default
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outputMode <= 3'h0;
    end else if (!fusesLoaded) begin
      outputMode <= fuseOutputMode;
    end else if (interfaceConfig[MODE_OVERRIDE_BIT]
        && (interfaceConfig[MODE_SELECT_MSB:MODE_SELECT_LSB] == MODE_TWO_WIRE
        || interfaceConfig[MODE_SELECT_MSB:MODE_SELECT_LSB] == MODE_ONE_WIRE
        || interfaceConfig[MODE_SELECT_MSB:MODE_SELECT_LSB] == MODE_HALF_WIRE)) begin
      outputMode <= interfaceConfig[MODE_SELECT_MSB:MODE_SELECT_LSB];
    end else begin
      outputMode <= defaultMode;
    end
  end

  assign globalOn = blockPowerDown[GLOBAL_POWERDOWN_BIT];

  // analog power controls merged with the global request; clock buffer and reference amp masked, channels unmasked, bandgap global only
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sampleClockBufferOff <= 1'b0;
      referenceAmpOff <= 1'b0;
      firstChannelOff <= 1'b0;
      secondChannelOff <= 1'b0;
      bandgapOff <= 1'b0;
    end else begin
      sampleClockBufferOff <= blockPowerDown[SAMPLE_CLOCK_BUFFER_OFF_BIT]
        || (globalOn && !maskClockBuffer);
      referenceAmpOff <= blockPowerDown[REFERENCE_AMP_OFF_BIT]
        || (globalOn && !maskReferenceAmp);
      firstChannelOff <= blockPowerDown[FIRST_CHANNEL_OFF_BIT] || globalOn;
      secondChannelOff <= blockPowerDown[SECOND_CHANNEL_OFF_BIT] || globalOn;
      bandgapOff <= globalOn && maskBandgapDisable;
    end
  end

  // output buffers follow their own bits only, whatever the mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frameClockOutputOff <= 1'b0;
      bitClockOutputOff <= 1'b0;
      firstChannelLane0Off <= 1'b0;
      firstChannelLane1Off <= 1'b0;
      secondChannelLane0Off <= 1'b0;
      secondChannelLane1Off <= 1'b0;
    end else begin
      frameClockOutputOff <= bufferPowerDown[FRAME_CLOCK_OUTPUT_OFF_BIT];
      bitClockOutputOff <= bufferPowerDown[BIT_CLOCK_OUTPUT_OFF_BIT];
      firstChannelLane0Off <= bufferPowerDown[FIRST_CHANNEL_LANE0_OFF_BIT];
      firstChannelLane1Off <= bufferPowerDown[FIRST_CHANNEL_LANE1_OFF_BIT];
      secondChannelLane0Off <= bufferPowerDown[SECOND_CHANNEL_LANE0_OFF_BIT];
      secondChannelLane1Off <= bufferPowerDown[SECOND_CHANNEL_LANE1_OFF_BIT];
    end
  end

  a_reset_clears: assert property (@(posedge clock) disable iff (!rst_n)
    softResetHit |=> interfaceConfig == 8'h00 && blockPowerDown == 8'h00
      && bufferPowerDown == 8'h00 && !fusesLoaded ##1 laneBitMapping == $past(fuseLaneMapping))
    else $error("soft reset did not restore defaults");

  a_map_hold: assert property (@(posedge clock) disable iff (!rst_n)
    fusesLoaded && !fuseLoadCmd && !softResetHit |=> $stable(laneBitMapping))
    else $error("lane mapping changed without fuse load");

  a_map_load: assert property (@(posedge clock) disable iff (!rst_n)
    fusesLoaded && fuseLoadCmd && !softResetHit
      && interfaceConfig[7:5] == 3'h3 |=> laneBitMapping == 3'h3)
    else $error("fuse load did not apply lane mapping");

  a_mode_default: assert property (@(posedge clock) disable iff (!rst_n)
    fusesLoaded && !softResetHit && !interfaceConfig[3] |=> outputMode == $past(defaultMode))
    else $error("mode changed without override");

  a_mode_select: assert property (@(posedge clock) disable iff (!rst_n)
    fusesLoaded && interfaceConfig[3:0] == 4'hd |=> outputMode == 3'h5)
    else $error("half wire mode not applied");

  a_clkbuf_off: assert property (@(posedge clock) disable iff (!rst_n)
    blockPowerDown[0] && !maskClockBuffer ##1 blockPowerDown[0] |-> sampleClockBufferOff)
    else $error("global power-down missed clock buffer");

  a_channel_off: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(blockPowerDown[2]) |=> firstChannelOff)
    else $error("first channel power-down late");

  a_lane_own: assert property (@(posedge clock) disable iff (!rst_n)
    ##1 firstChannelLane1Off == $past(bufferPowerDown[3])
      && secondChannelLane0Off == $past(bufferPowerDown[0]))
    else $error("lane buffer does not follow its own bit");
endmodule

// ==== test/ccp_host.sv ====
`timescale 1ns/1ps
module ccp_host (
  // serial clock and read data
  input wire logic clock,
  input wire logic sdataOut,
  // serial enable and data
  output logic senN,
  output logic sdataIn
);
  // idle between frames
  initial begin
    senN = 1'b1;
    sdataIn = 1'b0;
  end

  // one 24-bit frame, msb first; read bits are taken before the edge that
  // samples each data bit, so the capture never races the shift flop
  task automatic frame(input logic rd, input logic [11:0] a, input logic [7:0] d,
      output logic [7:0] q);
    logic [23:0] w;
    w = {rd, 3'h0, a, d}; // spare bits kept at zero
    q = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      senN = 1'b0;
      sdataIn = w[i];
      if (i < 8) q[i] = sdataOut;
      @(posedge clock);
      #1;
    end
    // released line shows the inverse rather than holding the last bit
    senN = 1'b1;
    sdataIn = ~w[0];
    @(posedge clock);
    #1;
  endtask
endmodule

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  import ccp_pkg::*;
  localparam logic [2:0] FUSE_MAP = 3'h2;
  localparam logic [2:0] FUSE_MODE = 3'h4;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic fuseLoadCmd = 1'b0;
  logic maskClockBuffer = 1'b0;
  logic maskReferenceAmp = 1'b0;
  logic maskBandgapDisable = 1'b1;
  logic senN, sdataIn, sdataOut;
  logic [2:0] laneBitMapping, outputMode;
  wire [4:0] pd;
  wire [5:0] ob;
  int errors = 0;
  int n_compared = 0;

  // device and host
  ccp_regs i_ccp_regs (.clock(clock), .rst_n(rst_n), .senN(senN), .sdataIn(sdataIn),
    .sdataOut(sdataOut), .fuseLaneMapping(FUSE_MAP), .fuseOutputMode(FUSE_MODE),
    .fuseLoadCmd(fuseLoadCmd), .maskClockBuffer(maskClockBuffer),
    .maskReferenceAmp(maskReferenceAmp), .maskBandgapDisable(maskBandgapDisable),
    .laneBitMapping(laneBitMapping), .outputMode(outputMode),
    .sampleClockBufferOff(pd[4]), .referenceAmpOff(pd[3]), .firstChannelOff(pd[2]),
    .secondChannelOff(pd[1]), .bandgapOff(pd[0]), .frameClockOutputOff(ob[5]),
    .bitClockOutputOff(ob[4]), .firstChannelLane1Off(ob[3]), .firstChannelLane0Off(ob[2]),
    .secondChannelLane1Off(ob[1]), .secondChannelLane0Off(ob[0]));
  ccp_host host (.clock(clock), .sdataOut(sdataOut), .senN(senN), .sdataIn(sdataIn));

  // 100 MHz
  always #5 clock = ~clock;

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask

  // outputs follow the register one edge after the frame's idle edge
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.frame(1'b0, a, d, q);
    @(posedge clock);
    #1;
  endtask

  task automatic rdchk(input string n, input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.frame(1'b1, a, 8'h00, q);
    chk(n, e, q);
  endtask

  task automatic reset_values();
    rdchk("reset reg", SOFTWARE_RESET_ADDR, 8'h00);
    rdchk("iface reg", OUTPUT_INTERFACE_CONFIG_ADDR, 8'h00);
    rdchk("block reg", BLOCK_POWER_DOWN_ADDR, 8'h00);
    rdchk("buffer reg", OUTPUT_BUFFER_POWER_DOWN_ADDR, 8'h00);
    rdchk("unmapped", 12'h0ab, 8'h00);
    chk("lane map", {5'h00, FUSE_MAP}, {5'h00, laneBitMapping});
    chk("mode", {5'h00, FUSE_MODE}, {5'h00, outputMode});
  endtask

  task automatic block_power();
    int b[4] = '{5, 4, 2, 1};
    for (int k = 0; k < 4; k++) begin
      wr(BLOCK_POWER_DOWN_ADDR, 8'h01 << b[k]);
      chk("block offs", {3'h0, 5'h10 >> k}, {3'h0, pd});
    end
    wr(BLOCK_POWER_DOWN_ADDR, 8'h01);
    chk("global offs", 8'h1f, {3'h0, pd});
    maskClockBuffer = 1'b1;
    maskReferenceAmp = 1'b1;
    maskBandgapDisable = 1'b0;
    wr(BLOCK_POWER_DOWN_ADDR, 8'hc9);
    chk("masked offs", 8'h06, {3'h0, pd});
    rdchk("reserved", BLOCK_POWER_DOWN_ADDR, 8'hc9);
    wr(BLOCK_POWER_DOWN_ADDR, 8'h00);
  endtask

  task automatic buffer_power();
    for (int k = 0; k < 6; k++) begin
      wr(OUTPUT_BUFFER_POWER_DOWN_ADDR, 8'h01 << k);
      chk("lane offs", 8'h01 << k, {2'h0, ob});
    end
    wr(OUTPUT_BUFFER_POWER_DOWN_ADDR, 8'h00);
  endtask

  task automatic mode_select();
    logic [2:0] m[3] = '{MODE_TWO_WIRE, MODE_ONE_WIRE, MODE_HALF_WIRE};
    wr(OUTPUT_INTERFACE_CONFIG_ADDR, 8'h05);
    chk("mode no override", {5'h00, FUSE_MODE}, {5'h00, outputMode});
    for (int k = 0; k < 3; k++) begin
      wr(OUTPUT_INTERFACE_CONFIG_ADDR, {5'h01, m[k]});
      chk("mode", {5'h00, m[k]}, {5'h00, outputMode});
    end
    chk("half wire lane offs", 8'h00, {2'h0, ob});
    wr(OUTPUT_INTERFACE_CONFIG_ADDR, 8'h0e);
    chk("unused mode", {5'h00, FUSE_MODE}, {5'h00, outputMode});
    rdchk("iface readback", OUTPUT_INTERFACE_CONFIG_ADDR, 8'h0e);
  endtask

  // mapping code 5 is unused, so the load falls back to the fuse value
  task automatic lane_map();
    logic [2:0] exp;
    exp = FUSE_MAP;
    for (int c = 1; c < 6; c++) begin
      wr(OUTPUT_INTERFACE_CONFIG_ADDR, {c[2:0], 5'h00});
      chk("lane before load", {5'h00, exp}, {5'h00, laneBitMapping});
      wr(BLOCK_POWER_DOWN_ADDR, 8'h20);
      fuseLoadCmd = 1'b1;
      @(posedge clock);
      #1;
      fuseLoadCmd = 1'b0;
      @(posedge clock);
      #1;
      exp = (c < 5) ? c[2:0] : FUSE_MAP;
      chk("lane after load", {5'h00, exp}, {5'h00, laneBitMapping});
      rdchk("block after load", BLOCK_POWER_DOWN_ADDR, 8'h00);
    end
  endtask

  task automatic soft_reset();
    wr(OUTPUT_BUFFER_POWER_DOWN_ADDR, 8'h3f);
    wr(OUTPUT_INTERFACE_CONFIG_ADDR, 8'h0b);
    wr(SOFTWARE_RESET_ADDR, 8'h01);
    chk("buffer offs", 8'h00, {2'h0, ob});
    chk("mode", {5'h00, FUSE_MODE}, {5'h00, outputMode});
    rdchk("buffer reg", OUTPUT_BUFFER_POWER_DOWN_ADDR, 8'h00);
    rdchk("reset bit", SOFTWARE_RESET_ADDR, 8'h00);
  endtask

  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence; after the reset values, interface setting and fuse load come first
  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    @(posedge clock);
    #1;
    reset_values();
    lane_map();
    mode_select();
    block_power();
    buffer_power();
    soft_reset();
    wrap_up();
  end

  // the run needs about 1200 cycles; this cuts a hang well beyond that
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
endmodule
